// ### gpio_pin_mux_pad_config.sv
// gpio_pin_mux_pad_config: eight-pin port mux, pad type and masked level read
// assumes a single clock; lower-lettered ports report their claims on claim_lower
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/10ps
`default_nettype none
// Contract
// - one function per pin at a time
// - lowest-letter port wins duplicate signal
// - pin mask bit n addresses pin n
// - masked read returns inputs and outputs alike
// - unselected pins read as zero
// - push-pull or open-drain drive per pin
// - weak pull-up or pull-down, never both
// - analog mode cuts digital paths
// - inputs feel only pull settings
module gpio_pin_mux_pad_config (
  // clock, reset, enable
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // register port
  input  wire logic [5:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata_q,
  // port-priority chain: bit f set when a lower port claims function f
  input  wire logic [15:0] claim_lower,
  output logic      [15:0] claim_out_q,
  // peripheral side: function f output value and enable
  input  wire logic [15:0] func_out,
  input  wire logic [15:0] func_oe,
  output logic      [15:0] func_in_q,
  output logic      [15:0] func_in_valid_q,
  // pads
  input  wire logic [7:0]  pad_in,
  output logic      [7:0]  pad_out_q,
  output logic      [7:0]  pad_oe_q,
  output logic      [7:0]  pull_up_q,
  output logic      [7:0]  pull_down_q,
  output logic      [7:0]  analog_en_q
);

  logic [31:0] func_all;
  logic [23:0] pad_all;
  logic [7:0]  gpio_dir_q;
  logic [7:0]  gpio_out_q;
  logic [7:0]  win;
  logic [7:0]  drv_val;
  logic [7:0]  drv_en;
  logic [7:0]  p_out, p_oe, p_pu, p_pd, p_din, p_ana;
  logic [7:0]  conflict_q;
  logic [15:0] claim_here;
  logic [15:0] fin_d, fval_d;
  logic        fsel_wr, pad_wr;
  logic [31:0] rdata_d;
  logic [2:0]  rb_idx;

  function automatic logic hit(input logic [5:0] a, input logic [5:0] off);
    return a == off;
  endfunction

  function automatic logic [3:0] fsel(input logic [31:0] all, input int p);
    return all[p*4 +: 4];
  endfunction

  assign fsel_wr = reg_wr && hit(reg_addr, pinmux_pkg::ADDR_FUNC_SEL);
  assign pad_wr  = reg_wr && hit(reg_addr, pinmux_pkg::ADDR_PAD_CFG);

  // one function code per pin: a pin can never carry two
  pin_cfg_store #(.W(4)) u_func (
    .clk     (clk),
    .rst     (rst),
    .ce      (ce),
    .wr_en   (fsel_wr),
    .wr_mask (reg_wdata[pinmux_pkg::FSEL_MASK_LSB +: 8]),
    .wr_data (reg_wdata[pinmux_pkg::FSEL_FUNC_LSB +: 4]),
    .rst_val (pinmux_pkg::FUNC_RESET),
    .rd_idx  (reg_wdata[pinmux_pkg::RB_PIN_LSB +: 3]),
    .rd_data (),
    .all_q   (func_all)
  );

  pin_cfg_store #(.W(3)) u_pad (
    .clk     (clk),
    .rst     (rst),
    .ce      (ce),
    .wr_en   (pad_wr),
    .wr_mask (reg_wdata[pinmux_pkg::PAD_MASK_LSB +: 8]),
    .wr_data (reg_wdata[pinmux_pkg::PAD_TYPE_LSB +: 3]),
    .rst_val (pinmux_pkg::PAD_RESET),
    .rd_idx  (reg_wdata[pinmux_pkg::RB_PIN_LSB +: 3]),
    .rd_data (),
    .all_q   (pad_all)
  );

  // plain gpio direction and output, mask-written as well
  always_ff @(posedge clk) begin
    if (rst) begin
      gpio_dir_q <= pinmux_pkg::DIR_RESET;
    end else if (ce && reg_wr && hit(reg_addr, pinmux_pkg::ADDR_GPIO_DIR)) begin
      gpio_dir_q <= (gpio_dir_q & ~reg_wdata[7:0]) | (reg_wdata[15:8] & reg_wdata[7:0]);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      gpio_out_q <= pinmux_pkg::OUT_RESET;
    end else if (ce && reg_wr && hit(reg_addr, pinmux_pkg::ADDR_GPIO_OUT)) begin
      gpio_out_q <= (gpio_out_q & ~reg_wdata[7:0]) | (reg_wdata[15:8] & reg_wdata[7:0]);
    end
  end

  // a pin's claim loses if a lower-lettered port already holds the signal;
  // within this port the lowest pin number wins so no signal drives twice
  always_comb begin
    claim_here = '0;
    win        = '0;
    drv_val    = '0;
    drv_en     = '0;
    for (int p = 0; p < 8; p++) begin
      if (fsel(func_all, p) == pinmux_pkg::FUNC_GPIO) begin
        win[p]     = 1'b1;
        drv_val[p] = gpio_out_q[p];
        drv_en[p]  = gpio_dir_q[p];
      end else if (!claim_lower[fsel(func_all, p)] &&
                   !claim_here[fsel(func_all, p)]) begin
        win[p]                         = 1'b1;
        claim_here[fsel(func_all, p)]  = 1'b1;
        drv_val[p]                     = func_out[fsel(func_all, p)];
        drv_en[p]                      = func_oe[fsel(func_all, p)];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_pad
      pad_ctrl u_pc (
        .pad_type  (pad_all[g*3 +: 3]),
        .drv_val   (drv_val[g]),
        .drv_en    (drv_en[g]),
        .pad_out   (p_out[g]),
        .pad_oe    (p_oe[g]),
        .pull_up   (p_pu[g]),
        .pull_down (p_pd[g]),
        .dig_in_en (p_din[g]),
        .analog_en (p_ana[g])
      );
    end
  endgenerate

  // route pad levels back to the winning peripheral inputs
  always_comb begin
    fin_d  = '0;
    fval_d = '0;
    for (int p = 0; p < 8; p++) begin
      if (win[p] && fsel(func_all, p) != pinmux_pkg::FUNC_GPIO && p_din[p]) begin
        fin_d[fsel(func_all, p)]  = pad_in[p]; // analog pins give nothing
        fval_d[fsel(func_all, p)] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pad_out_q   <= '0;
      pad_oe_q    <= '0;
      pull_up_q   <= '0;
      pull_down_q <= '0;
      analog_en_q <= '0;
    end else if (ce) begin
      pad_out_q   <= p_out;
      pad_oe_q    <= p_oe;
      pull_up_q   <= p_pu;
      pull_down_q <= p_pd;
      analog_en_q <= p_ana;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      func_in_q       <= '0;
      func_in_valid_q <= '0;
      claim_out_q     <= '0;
    end else if (ce) begin
      func_in_q       <= fin_d;
      func_in_valid_q <= fval_d;
      claim_out_q     <= claim_lower | claim_here; // passes priority upward
    end
  end

  // sticky per-pin flag: a peripheral selection that lost to another owner
  always_ff @(posedge clk) begin
    if (rst) begin
      conflict_q <= '0;
    end else if (ce) begin
      for (int p = 0; p < 8; p++) begin
        if (!win[p]) begin
          conflict_q[p] <= 1'b1; // set wins over clear
        end else if (reg_wr && hit(reg_addr, pinmux_pkg::ADDR_CONFLICT) && reg_wdata[p]) begin
          conflict_q[p] <= 1'b0;
        end
      end
    end
  end

  // read mux; readback taps the cells directly so data land one cycle after the strobe
  always_comb begin
    rdata_d = 32'h00000000;
    rb_idx  = reg_wdata[pinmux_pkg::RB_PIN_LSB +: 3];
    if (reg_rd) begin
      unique case (reg_addr)
        // pad level, whatever the direction; unmasked and analog bits zero
        pinmux_pkg::ADDR_LEVEL_READ: rdata_d = {24'h000000, pad_in & p_din & reg_wdata[7:0]};
        pinmux_pkg::ADDR_GPIO_DIR:   rdata_d = {24'h000000, gpio_dir_q};
        pinmux_pkg::ADDR_GPIO_OUT:   rdata_d = {24'h000000, gpio_out_q};
        pinmux_pkg::ADDR_FUNC_RB:    rdata_d = {28'h0000000, fsel(func_all, int'(rb_idx))};
        pinmux_pkg::ADDR_PAD_RB:     rdata_d = {29'h00000000, pad_all[int'(rb_idx)*3 +: 3]};
        pinmux_pkg::ADDR_CONFLICT:   rdata_d = {24'h000000, conflict_q};
        default:                     rdata_d = 32'h00000000;
      endcase
    end
  end

  // read data stand one cycle only, then fall back to zero
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata_q <= '0;
    end else if (ce) begin
      reg_rdata_q <= rdata_d;
    end
  end

endmodule
`default_nettype wire

// ### pinmux_pkg.sv
// pinmux_pkg: register map, field layout and encodings of the eight-pin port mux
// assumes a plain strobe register port with 32-bit data and byte offsets
package pinmux_pkg;

  localparam int NUM_PINS   = 8;
  localparam int NUM_FUNCS  = 16;
  localparam int FUNC_W     = 4;
  localparam int ADDR_W     = 6;

  // register offsets (byte addresses)
  localparam logic [5:0] ADDR_FUNC_SEL   = 6'h00;
  localparam logic [5:0] ADDR_PAD_CFG    = 6'h04;
  localparam logic [5:0] ADDR_LEVEL_READ = 6'h08;
  localparam logic [5:0] ADDR_GPIO_DIR   = 6'h0C;
  localparam logic [5:0] ADDR_GPIO_OUT   = 6'h10;
  localparam logic [5:0] ADDR_FUNC_RB    = 6'h14;
  localparam logic [5:0] ADDR_PAD_RB     = 6'h18;
  localparam logic [5:0] ADDR_CONFLICT   = 6'h1C;

  // function select write: [7:0] pin mask, [11:8] function code
  localparam int FSEL_MASK_LSB = 0;
  localparam int FSEL_FUNC_LSB = 8;
  // pad config write: [7:0] pin mask, [10:8] pad type
  localparam int PAD_MASK_LSB  = 0;
  localparam int PAD_TYPE_LSB  = 8;
  localparam int PAD_TYPE_W    = 3;
  // readback select field: pin index in [2:0]
  localparam int RB_PIN_LSB    = 0;

  // function code 0 is plain gpio; 1..15 are peripheral signals
  localparam logic [3:0] FUNC_GPIO = 4'h0;

  typedef enum logic [2:0] {
    pad_push_pull      = 3'b000,
    pad_push_pull_wpu  = 3'b001,
    pad_push_pull_wpd  = 3'b010,
    pad_open_drain     = 3'b011,
    pad_open_drain_wpu = 3'b100,
    pad_open_drain_wpd = 3'b101,
    pad_analog         = 3'b110
  } pad_type_t;

  localparam logic [2:0] PAD_RESET  = 3'b000;
  localparam logic [3:0] FUNC_RESET = 4'h0;
  localparam logic [7:0] DIR_RESET  = 8'h00;
  localparam logic [7:0] OUT_RESET  = 8'h00;

endpackage

// ### pin_cfg_store.sv
// pin_cfg_store: per-pin configuration words, mask-written, registered readback
// assumes writes arrive one per cycle from the register slave
`timescale 1ns/10ps
`default_nettype none
module pin_cfg_store #(
  parameter int W = 4
) (
  // clock and control
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  // mask write
  input  wire logic             wr_en,
  input  wire logic [7:0]       wr_mask,
  input  wire logic [W-1:0]     wr_data,
  input  wire logic [W-1:0]     rst_val,
  // contents and readback
  input  wire logic [2:0]       rd_idx,
  output logic      [W-1:0]     rd_data,
  output logic      [8*W-1:0]   all_q
);

  logic [W-1:0] cell_q [8];

  // one process owns the whole array so no cell has two drivers
  // only masked pins change
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int p = 0; p < 8; p++) begin
        cell_q[p] <= rst_val;
      end
    end else if (ce && wr_en) begin
      for (int p = 0; p < 8; p++) begin
        if (wr_mask[p]) begin
          cell_q[p] <= wr_data;
        end
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_cell
      assign all_q[g*W +: W] = cell_q[g];
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data <= '0;
    end else if (ce) begin
      rd_data <= cell_q[rd_idx];
    end
  end

endmodule
`default_nettype wire

// ### pad_ctrl.sv
// pad_ctrl: turns one pin's pad type and drive request into pad controls
// assumes the pad ring resolves the wire from drive/enable/pull
`timescale 1ns/10ps
`default_nettype none
module pad_ctrl (
  // configuration
  input  wire logic [2:0] pad_type,
  // drive request from selected source
  input  wire logic       drv_val,
  input  wire logic       drv_en,
  // pad controls
  output logic            pad_out,
  output logic            pad_oe,
  output logic            pull_up,
  output logic            pull_down,
  output logic            dig_in_en,
  output logic            analog_en
);

  always_comb begin
    pad_out   = 1'b0;
    pad_oe    = 1'b0;
    pull_up   = 1'b0;
    pull_down = 1'b0;
    dig_in_en = 1'b1;
    analog_en = 1'b0;
    unique case (pad_type)
      pinmux_pkg::pad_push_pull,
      pinmux_pkg::pad_push_pull_wpu,
      pinmux_pkg::pad_push_pull_wpd: begin
        pad_out = drv_val;
        pad_oe  = drv_en;
      end
      pinmux_pkg::pad_open_drain,
      pinmux_pkg::pad_open_drain_wpu,
      pinmux_pkg::pad_open_drain_wpd: begin
        pad_out = 1'b0;
        pad_oe  = drv_en & ~drv_val; // only low is driven
      end
      pinmux_pkg::pad_analog: begin
        dig_in_en = 1'b0; // digital paths cut
        analog_en = 1'b1;
      end
      default: begin
        dig_in_en = 1'b1;
      end
    endcase
    // at most one pull is on, by encoding
    pull_up   = (pad_type == pinmux_pkg::pad_push_pull_wpu) ||
                (pad_type == pinmux_pkg::pad_open_drain_wpu);
    pull_down = (pad_type == pinmux_pkg::pad_push_pull_wpd) ||
                (pad_type == pinmux_pkg::pad_open_drain_wpd);
  end

endmodule
`default_nettype wire

// ### gpio_pin_mux_pad_config_sva.sv
// checker: port-level properties of the pin mux
// assumes bind onto the top module with ce held high
`timescale 1ns/10ps
`default_nettype none
module gpio_pin_mux_pad_config_sva (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // register port
  input wire logic [5:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata_q,
  // claim chain and pads
  input wire logic [15:0] claim_lower,
  input wire logic [15:0] claim_out_q,
  input wire logic [15:0] func_in_valid_q,
  input wire logic [7:0]  pad_in,
  input wire logic [7:0]  pad_oe_q,
  input wire logic [7:0]  pull_up_q,
  input wire logic [7:0]  pull_down_q,
  input wire logic [7:0]  analog_en_q
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  logic lvl_rd;
  assign lvl_rd = reg_rd && reg_addr == pinmux_pkg::ADDR_LEVEL_READ;
  property p_lvl;
    !$past(rst) && $past(lvl_rd) |-> reg_rdata_q[7:0] ==
      ($past(pad_in) & $past(reg_wdata[7:0]) & ~$past(analog_en_q));
  endproperty
  a_lvl: assert property (p_lvl) else $error("level read wrong");
  property p_unsel;
    $past(lvl_rd) |-> (reg_rdata_q[7:0] & ~$past(reg_wdata[7:0])) == 8'h00;
  endproperty
  a_unsel: assert property (p_unsel) else $error("unselected pin set");
  property p_hi;
    $past(lvl_rd) |-> reg_rdata_q[31:8] == 24'h000000;
  endproperty
  a_hi: assert property (p_hi) else $error("upper bits set");
  property p_idle;
    !$past(reg_rd) |-> reg_rdata_q == 32'h00000000;
  endproperty
  a_idle: assert property (p_idle) else $error("read data outlived");
  property p_pull;
    (pull_up_q & pull_down_q) == 8'h00;
  endproperty
  a_pull: assert property (p_pull) else $error("both pulls on");
  property p_ana;
    (analog_en_q & (pad_oe_q | pull_up_q | pull_down_q)) == 8'h00;
  endproperty
  a_ana: assert property (p_ana) else $error("analog pin driven");
  property p_claim;
    !$past(rst) |-> ($past(claim_lower) & ~claim_out_q) == 16'h0000;
  endproperty
  a_claim: assert property (p_claim) else $error("claim dropped");
  property p_lose;
    !$past(rst) && $stable(claim_lower) |-> (func_in_valid_q & claim_lower) == 16'h0000;
  endproperty
  a_lose: assert property (p_lose) else $error("lower port overruled");
  c_lvl: cover property (lvl_rd);
  c_ana: cover property (|analog_en_q);
  c_claim: cover property (|claim_lower);
endmodule
bind gpio_pin_mux_pad_config gpio_pin_mux_pad_config_sva u_sva (
  .clk, .rst, .reg_addr, .reg_wdata, .reg_rd, .reg_rdata_q, .claim_lower,
  .claim_out_q, .func_in_valid_q, .pad_in, .pad_oe_q, .pull_up_q, .pull_down_q,
  .analog_en_q
);
`default_nettype wire

// ### pin_partner.sv
// pin_partner: pad ring and peripheral functions facing the port
// assumes pad controls come straight from the mux outputs
`timescale 1ns/10ps
`default_nettype none
module pin_partner #(
  parameter logic [15:0] FOUT = 16'h0020
) (
  // clock
  input  wire logic        clk,
  // pad controls
  input  wire logic [7:0]  pad_out_q,
  input  wire logic [7:0]  pad_oe_q,
  input  wire logic [7:0]  pull_up_q,
  input  wire logic [7:0]  pull_down_q,
  // levels and peripheral drive
  output logic      [7:0]  pad_in,
  output logic      [15:0] func_out,
  output logic      [15:0] func_oe
);
  // undriven unpulled pad toggles so a stale level never reads back
  logic [7:0] flt_q = 8'h55;
  always @(posedge clk) begin
    flt_q <= ~flt_q;
  end
  assign pad_in = (pad_oe_q & pad_out_q) |
    (~pad_oe_q & (pull_up_q | (~pull_down_q & flt_q)));
  assign func_out = FOUT;
  assign func_oe = 16'hFFFF;
endmodule
`default_nettype wire

// ### gpio_pin_mux_pad_config_tb.sv
// gpio_pin_mux_pad_config_tb: register-driven checks of mux, pads and level read
// assumes pin_partner closes the pad loop; ce held high
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch at %0t: got %h want %h", $time, g, e); end end
module gpio_pin_mux_pad_config_tb;
  localparam logic [5:0] PAD = pinmux_pkg::ADDR_PAD_CFG;
  localparam logic [5:0] LVL = pinmux_pkg::ADDR_LEVEL_READ;
  localparam logic [5:0] FSEL = pinmux_pkg::ADDR_FUNC_SEL;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [5:0]  reg_addr = 6'h00;
  logic [31:0] reg_wdata = 32'h00000000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] claim_lower = 16'h0000;
  logic [31:0] reg_rdata_q;
  logic [15:0] claim_out_q, func_out, func_oe, func_in_q, func_in_valid_q;
  logic [7:0]  pad_in, pad_out_q, pad_oe_q, pull_up_q, pull_down_q, analog_en_q;
  logic [7:0]  m, oe_e, lv_e;
  logic        pu, pd, an, od;
  int          n_fail = 0;
  int          checks_done = 0;
  int          cyc = 0;
  always #2.5 clk = ~clk;
  gpio_pin_mux_pad_config uut (.clk, .rst, .ce(1'b1), .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata_q, .claim_lower, .claim_out_q, .func_out, .func_oe, .func_in_q,
    .func_in_valid_q, .pad_in, .pad_out_q, .pad_oe_q, .pull_up_q, .pull_down_q,
    .analog_en_q);
  pin_partner far (.clk, .pad_out_q, .pad_oe_q, .pull_up_q, .pull_down_q, .pad_in,
    .func_out, .func_oe);
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] mk, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    reg_wdata <= {24'h000000, mk};
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata_q, e)
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ceiling well above the roughly 110 cycles the sequence needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      finish_test();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    wt(1);
    `CHK(pad_oe_q | pull_up_q | analog_en_q, 8'h00)
    wr(pinmux_pkg::ADDR_GPIO_DIR, 32'h0000FFFF);
    wr(pinmux_pkg::ADDR_GPIO_OUT, 32'h00000FFF);
    for (int t = 0; t < 7; t++) begin
      pu = t == 1 || t == 4;
      pd = t == 2 || t == 5;
      od = t >= 3 && t <= 5;
      an = t == 6;
      oe_e = an ? 8'h00 : od ? 8'hF0 : 8'hFF;
      lv_e = an ? 8'h00 : od ? (pu ? 8'h0F : 8'h00) : 8'h0F;
      m = t == 3 ? 8'hF0 : 8'h3C;
      wr(PAD, {21'h000000, t[2:0], 8'hFF});
      wt(3);
      `CHK(pad_oe_q, oe_e)
      `CHK(pad_out_q & oe_e, 8'h0F & oe_e)
      `CHK({pull_up_q, pull_down_q}, {{8{pu}}, {8{pd}}})
      `CHK(analog_en_q, {8{an}})
      rd(LVL, m, {24'h000000, lv_e & m});
    end
    wr(pinmux_pkg::ADDR_GPIO_DIR, 32'h000000FF);
    wr(PAD, 32'h000001FF);
    wt(3);
    `CHK(pad_oe_q, 8'h00)
    rd(LVL, 8'hFF, 32'h000000FF);
    wr(PAD, 32'h000005FF);
    wt(2);
    rd(LVL, 8'h81, 32'h00000000);
    wr(PAD, 32'h000000FF);
    wr(PAD, 32'h00000601);
    wr(PAD, 32'h00000580);
    wt(3);
    `CHK(analog_en_q, 8'h01)
    `CHK(pull_down_q, 8'h80)
    wr(FSEL, 32'h00000504);
    wt(3);
    `CHK({pad_oe_q[2], pad_out_q[2], func_in_q[5]}, 3'b111)
    rd(pinmux_pkg::ADDR_FUNC_RB, 8'h02, 32'h00000005);
    rd(pinmux_pkg::ADDR_PAD_RB, 8'h07, 32'h00000005);
    `CHK({func_in_valid_q[5], claim_out_q[5]}, 2'b11)
    @(posedge clk);
    claim_lower <= 16'h0020;
    wt(3);
    `CHK({func_in_valid_q[5], pad_oe_q[2], claim_out_q[5]}, 3'b001)
    rd(pinmux_pkg::ADDR_CONFLICT, 8'h00, 32'h00000004);
    @(posedge clk);
    claim_lower <= 16'h0000;
    wr(FSEL, 32'h00000704);
    wt(3);
    `CHK({func_in_valid_q[5], func_in_valid_q[7], pad_out_q[2]}, 3'b010)
    rd(6'h3C, 8'hFF, 32'h00000000);
    finish_test();
  end
endmodule
`default_nettype wire
